// *** bsim_pkg.sv ***
package bsim_pkg;

	////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int NUM_PE = 8;
	localparam int PPI_W = 16;
	localparam int SGI_NUM = 8;
	localparam int MSI_ID_W = 16;
	localparam int INTX_W = 4;
	localparam int PE_CNT_W = 5;
	localparam logic [PE_CNT_W-1:0] V2_MAX_PE = 5'h08;
	localparam logic [3:0] SGI_LIMIT = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// private interrupt identifiers, private window starts at 16
	localparam logic [4:0] PPI_BASE = 5'h10;
	localparam logic [4:0] ID_NS_PHYS_TMR = 5'h1e;
	localparam logic [4:0] ID_SEC_PHYS_TMR = 5'h1d;
	localparam logic [4:0] ID_NS_EL2_VIRT_TMR = 5'h1c;
	localparam logic [4:0] ID_VIRT_TMR = 5'h1b;
	localparam logic [4:0] ID_NS_EL2_PHYS_TMR = 5'h1a;
	localparam logic [4:0] ID_MAINT = 5'h19;
	localparam logic [4:0] ID_CROSS_TRIG = 5'h18;
	localparam logic [4:0] ID_PMU = 5'h17;
	localparam logic [4:0] ID_DEBUG_COMM = 5'h16;
	localparam logic [4:0] ID_PROF_BUF = 5'h15;
	localparam logic [4:0] ID_SEL2_PHYS_TMR = 5'h14;
	localparam logic [4:0] ID_SEL2_VIRT_TMR = 5'h13;

	////////////////////////////////////////////////////////////////////////
	// modes and states
	typedef enum logic [1:0] {
		ARCH_V2 = 2'b00,
		ARCH_V2M = 2'b01,
		ARCH_V3 = 2'b10,
		ARCH_RSVD = 2'b11
	} bsim_arch_t;

	typedef enum logic [1:0] {
		CFG_RESET = 2'b00,
		CFG_CHECK = 2'b01,
		CFG_RUN = 2'b10,
		CFG_FAULT = 2'b11
	} bsim_cfg_state_t;

	////////////////////////////////////////////////////////////////////////
	// bit of the private vector that an identifier lands on
	function automatic logic [PPI_W-1:0] bsim_ppi_onehot(
		input logic [4:0] id
	);
		logic [4:0] ofs;
		ofs = id - PPI_BASE;
		bsim_ppi_onehot = 16'h0001 << ofs[3:0];
	endfunction : bsim_ppi_onehot

	// flat index of a software interrupt pending bit
	function automatic logic [5:0] bsim_sgi_idx(
		input logic [2:0] pe,
		input logic [2:0] id
	);
		bsim_sgi_idx = {pe, id};
	endfunction : bsim_sgi_idx

endpackage : bsim_pkg

// *** bsim_ppi_map.sv ***
module bsim_ppi_map
	import bsim_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_prof_en,
	input wire logic i_sel2_en,
	input wire logic i_ns_el2_virt_en,
	input wire logic i_ns_phys_timer_irq,
	input wire logic i_virt_timer_irq,
	input wire logic i_cross_trigger_irq,
	input wire logic i_pmu_irq,
	input wire logic i_debug_comm_channel_irq,
	input wire logic i_profiling_buffer_irq,
	input wire logic i_ns_el2_virt_timer_irq,
	input wire logic i_ns_el2_phys_timer_irq,
	input wire logic i_maint_irq,
	input wire logic i_secure_phys_timer_irq,
	input wire logic i_secure_el2_phys_timer_irq,
	input wire logic i_secure_el2_virt_timer_irq,
	output logic [PPI_W-1:0] o_ppi
);

	typedef struct packed {
		logic [PPI_W-1:0] ppi;
	} bsim_map_t;

	bsim_map_t q;
	bsim_map_t next_q;

	// each level source onto its own private line
	always_comb begin
		next_q = q;
		next_q.ppi = '0;
		if (i_ns_phys_timer_irq) next_q.ppi |= bsim_ppi_onehot(ID_NS_PHYS_TMR);
		if (i_virt_timer_irq) next_q.ppi |= bsim_ppi_onehot(ID_VIRT_TMR);
		if (i_cross_trigger_irq) next_q.ppi |= bsim_ppi_onehot(ID_CROSS_TRIG);
		if (i_pmu_irq) next_q.ppi |= bsim_ppi_onehot(ID_PMU);
		if (i_debug_comm_channel_irq) next_q.ppi |= bsim_ppi_onehot(ID_DEBUG_COMM);
		if (i_profiling_buffer_irq && i_prof_en) next_q.ppi |= bsim_ppi_onehot(ID_PROF_BUF);
		if (i_ns_el2_virt_timer_irq && i_ns_el2_virt_en) next_q.ppi |= bsim_ppi_onehot(ID_NS_EL2_VIRT_TMR);
		if (i_ns_el2_phys_timer_irq) next_q.ppi |= bsim_ppi_onehot(ID_NS_EL2_PHYS_TMR);
		if (i_maint_irq) next_q.ppi |= bsim_ppi_onehot(ID_MAINT);
		if (i_secure_phys_timer_irq) next_q.ppi |= bsim_ppi_onehot(ID_SEC_PHYS_TMR);
		if (i_secure_el2_phys_timer_irq && i_sel2_en) next_q.ppi |= bsim_ppi_onehot(ID_SEL2_PHYS_TMR);
		if (i_secure_el2_virt_timer_irq && i_sel2_en) next_q.ppi |= bsim_ppi_onehot(ID_SEL2_VIRT_TMR);
	end

	// register the private lines
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign o_ppi = q.ppi;

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_pmu_direct;
		@(posedge i_clk) disable iff (i_srst)
		i_pmu_irq |=> o_ppi[7] ##1 (o_ppi[7] == $past(i_pmu_irq));
	endproperty
	a_pmu_direct: assert property (p_pmu_direct) else $error("pmu line lost");

	property p_ns_timer_line;
		@(posedge i_clk) disable iff (i_srst)
		!i_ns_phys_timer_irq |=> !o_ppi[14];
	endproperty
	a_ns_timer_line: assert property (p_ns_timer_line) else $error("timer line stuck");

endmodule : bsim_ppi_map

// *** bsim_sgi_bank.sv ***
module bsim_sgi_bank
	import bsim_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_set_valid,
	input wire logic [2:0] i_set_id,
	input wire logic [NUM_PE-1:0] i_set_targets,
	input wire logic i_clr_valid,
	input wire logic [2:0] i_clr_pe,
	input wire logic [2:0] i_clr_id,
	output logic [NUM_PE*SGI_NUM-1:0] o_pend
);

	typedef struct packed {
		logic [NUM_PE*SGI_NUM-1:0] pend;
	} bsim_bank_t;

	bsim_bank_t q;
	bsim_bank_t next_q;

	// clear first so a same-cycle set wins
	always_comb begin
		next_q = q;
		if (i_clr_valid) begin
			next_q.pend[bsim_sgi_idx(i_clr_pe, i_clr_id)] = 1'b0;
		end
		for (int p = 0; p < NUM_PE; p++) begin
			if (i_set_valid && i_set_targets[p]) begin
				next_q.pend[bsim_sgi_idx(3'(p), i_set_id)] = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign o_pend = q.pend;

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_set_wins;
		@(posedge i_clk) disable iff (i_srst)
		(i_set_valid && i_set_targets[0] && i_clr_valid && i_clr_pe == 3'h0
			&& i_clr_id == i_set_id) |=> o_pend[$past(i_set_id)];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

endmodule : bsim_sgi_bank

// *** bsim_top.sv ***
// Operation
// - present v2, v2 with frames, or v3
// - v2 limited to eight elements, no pcie
// - v3 without translation only without pcie
// - pcie with v3 needs translation, locality
// - v3 supports both security states
// - v3 pcie messages go to locality
// - legacy pcie lines delivered as levels
// - eight non-secure software interrupts, ids 0-7
// - listed sources use private lines only
// - private lines sit in ids 16-31
// - physical timer 30, virtual timer 27
// - cross trigger on line 24
// - performance monitor overflow on line 23
// - debug channel on line 22
// - profiling buffer on line 21 if present
// - el2 virtual timer 28 on 8.1
// - el2 physical timer on line 26
// - maintenance interrupt on line 25
// - secure physical timer on line 29
// - secure el2 timers on 20, 19
// - monitor overflow unique line, no logic
module bsim_top
	import bsim_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_SRST,
	input wire logic [1:0] I_ARCH_SEL,
	input wire logic I_HAS_PCIE,
	input wire logic I_HAS_MSG_TRANSLATION_SERVICE,
	input wire logic [PE_CNT_W-1:0] I_PE_COUNT,
	input wire logic I_PROF_PRESENT,
	input wire logic I_SEL2_PRESENT,
	input wire logic I_PE_V81,
	input wire logic [NUM_PE-1:0] I_NS_PHYS_TIMER_IRQ,
	input wire logic [NUM_PE-1:0] I_VIRT_TIMER_IRQ,
	input wire logic [NUM_PE-1:0] I_CROSS_TRIGGER_IRQ,
	input wire logic [NUM_PE-1:0] I_PMU_OVERFLOW_IRQ,
	input wire logic [NUM_PE-1:0] I_DEBUG_COMM_CHANNEL_IRQ,
	input wire logic [NUM_PE-1:0] I_PROFILING_BUFFER_IRQ,
	input wire logic [NUM_PE-1:0] I_NS_EL2_VIRT_TIMER_IRQ,
	input wire logic [NUM_PE-1:0] I_NS_EL2_PHYS_TIMER_IRQ,
	input wire logic [NUM_PE-1:0] I_MAINT_IRQ,
	input wire logic [NUM_PE-1:0] I_SECURE_PHYS_TIMER_IRQ,
	input wire logic [NUM_PE-1:0] I_SECURE_EL2_PHYS_TIMER_IRQ,
	input wire logic [NUM_PE-1:0] I_SECURE_EL2_VIRT_TIMER_IRQ,
	input wire logic I_SGI_VALID,
	input wire logic [3:0] I_SGI_ID,
	input wire logic [NUM_PE-1:0] I_SGI_TARGETS,
	input wire logic I_SGI_ACK_VALID,
	input wire logic [2:0] I_SGI_ACK_PE,
	input wire logic [2:0] I_SGI_ACK_ID,
	input wire logic I_MSI_VALID,
	input wire logic [MSI_ID_W-1:0] I_MSI_DATA,
	input wire logic [INTX_W-1:0] I_INTX,
	output logic [NUM_PE*PPI_W-1:0] O_PPI_LEVEL,
	output logic [NUM_PE*SGI_NUM-1:0] O_SGI_PEND,
	output logic O_SGI_REJECT,
	output logic O_MSI_SPI_VALID,
	output logic [MSI_ID_W-1:0] O_MSI_SPI_ID,
	output logic O_MSI_LPI_VALID,
	output logic [MSI_ID_W-1:0] O_MSI_LPI_ID,
	output logic O_MSI_DROP,
	output logic [INTX_W-1:0] O_INTX_LEVEL,
	output logic O_CFG_VALID,
	output logic O_CFG_FAULT,
	output logic O_SEC_TWO_STATES
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		bsim_cfg_state_t st;
		bsim_arch_t arch;
		logic pcie;
		logic mts;
		logic [PE_CNT_W-1:0] pe_cnt;
		logic prof;
		logic sel2;
		logic v81;
		logic sgi_reject;
		logic spi_valid;
		logic [MSI_ID_W-1:0] spi_id;
		logic lpi_valid;
		logic [MSI_ID_W-1:0] lpi_id;
		logic drop;
		logic [INTX_W-1:0] intx;
		logic cfg_valid;
		logic cfg_fault;
		logic sec_two;
	} bsim_top_t;

	bsim_top_t q;
	bsim_top_t next_q;

	logic cfg_ok;
	logic sgi_in_range;
	logic running;

	////////////////////////////////////////////////////////////////////////
	// configuration checks on latched straps

	always_comb begin
		cfg_ok = 1'b0;
		unique case (q.arch)
			ARCH_V2: begin
				cfg_ok = (q.pe_cnt <= V2_MAX_PE) && !q.pcie;
			end
			ARCH_V2M: begin
				cfg_ok = (q.pe_cnt <= V2_MAX_PE);
			end
			ARCH_V3: begin
				cfg_ok = !q.pcie || q.mts;
			end
			ARCH_RSVD: begin
				cfg_ok = 1'b0;
			end
		endcase
	end

	assign running = (q.st == CFG_RUN);
	assign sgi_in_range = (I_SGI_ID < SGI_LIMIT);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_q = q;
		next_q.sgi_reject = 1'b0;
		next_q.spi_valid = 1'b0;
		next_q.lpi_valid = 1'b0;
		next_q.drop = 1'b0;
		// configuration sequence
		unique case (q.st)
			CFG_RESET: begin
				// straps caught on the first edge after release
				next_q.arch = bsim_arch_t'(I_ARCH_SEL);
				next_q.pcie = I_HAS_PCIE;
				next_q.mts = I_HAS_MSG_TRANSLATION_SERVICE;
				next_q.pe_cnt = I_PE_COUNT;
				next_q.prof = I_PROF_PRESENT;
				next_q.sel2 = I_SEL2_PRESENT;
				next_q.v81 = I_PE_V81;
				next_q.st = CFG_CHECK;
			end
			CFG_CHECK: begin
				if (cfg_ok) begin
					next_q.st = CFG_RUN;
					next_q.cfg_valid = 1'b1;
					next_q.sec_two = (q.arch == ARCH_V3);
				end else begin
					next_q.st = CFG_FAULT;
					next_q.cfg_fault = 1'b1;
				end
			end
			CFG_RUN: begin
				next_q.st = CFG_RUN;
			end
			CFG_FAULT: begin
				next_q.st = CFG_FAULT;
			end
		endcase
		// software interrupt range check
		if (I_SGI_VALID && !sgi_in_range) begin
			next_q.sgi_reject = 1'b1;
		end
		// message interrupt routing
		if (I_MSI_VALID) begin
			if (running && q.pcie && q.arch == ARCH_V3 && q.mts) begin
				next_q.lpi_valid = 1'b1;
				next_q.lpi_id = I_MSI_DATA;
			end else if (running && q.pcie && q.arch == ARCH_V2M) begin
				next_q.spi_valid = 1'b1;
				next_q.spi_id = I_MSI_DATA;
			end else begin
				next_q.drop = 1'b1;
			end
		end
		// legacy lines follow their source level
		if (running && q.pcie) begin
			next_q.intx = I_INTX;
		end else begin
			next_q.intx = '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// private lines, one mapper per element

	for (genvar g = 0; g < NUM_PE; g++) begin : g_pe
		bsim_ppi_map u_map (
			.i_clk(I_CLK),
			.i_srst(I_SRST),
			.i_prof_en(q.prof),
			.i_sel2_en(q.sel2),
			.i_ns_el2_virt_en(q.v81),
			.i_ns_phys_timer_irq(I_NS_PHYS_TIMER_IRQ[g]),
			.i_virt_timer_irq(I_VIRT_TIMER_IRQ[g]),
			.i_cross_trigger_irq(I_CROSS_TRIGGER_IRQ[g]),
			.i_pmu_irq(I_PMU_OVERFLOW_IRQ[g]),
			.i_debug_comm_channel_irq(I_DEBUG_COMM_CHANNEL_IRQ[g]),
			.i_profiling_buffer_irq(I_PROFILING_BUFFER_IRQ[g]),
			.i_ns_el2_virt_timer_irq(I_NS_EL2_VIRT_TIMER_IRQ[g]),
			.i_ns_el2_phys_timer_irq(I_NS_EL2_PHYS_TIMER_IRQ[g]),
			.i_maint_irq(I_MAINT_IRQ[g]),
			.i_secure_phys_timer_irq(I_SECURE_PHYS_TIMER_IRQ[g]),
			.i_secure_el2_phys_timer_irq(I_SECURE_EL2_PHYS_TIMER_IRQ[g]),
			.i_secure_el2_virt_timer_irq(I_SECURE_EL2_VIRT_TIMER_IRQ[g]),
			.o_ppi(O_PPI_LEVEL[g*PPI_W +: PPI_W])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// software generated interrupts

	bsim_sgi_bank u_sgi (
		.i_clk(I_CLK),
		.i_srst(I_SRST),
		.i_set_valid(I_SGI_VALID && sgi_in_range),
		.i_set_id(I_SGI_ID[2:0]),
		.i_set_targets(I_SGI_TARGETS),
		.i_clr_valid(I_SGI_ACK_VALID),
		.i_clr_pe(I_SGI_ACK_PE),
		.i_clr_id(I_SGI_ACK_ID),
		.o_pend(O_SGI_PEND)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign O_SGI_REJECT = q.sgi_reject;
	assign O_MSI_SPI_VALID = q.spi_valid;
	assign O_MSI_SPI_ID = q.spi_id;
	assign O_MSI_LPI_VALID = q.lpi_valid;
	assign O_MSI_LPI_ID = q.lpi_id;
	assign O_MSI_DROP = q.drop;
	assign O_INTX_LEVEL = q.intx;
	assign O_CFG_VALID = q.cfg_valid;
	assign O_CFG_FAULT = q.cfg_fault;
	assign O_SEC_TWO_STATES = q.sec_two;

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_check_v3_pcie_no_mts;
		q.st == CFG_CHECK && q.arch == ARCH_V3 && q.pcie && !q.mts;
	endsequence

	sequence s_fault_held;
		O_CFG_FAULT && !O_CFG_VALID [*3];
	endsequence

	property p_v3_needs_mts;
		@(posedge I_CLK) disable iff (I_SRST)
		s_check_v3_pcie_no_mts |=> s_fault_held;
	endproperty
	a_v3_needs_mts: assert property (p_v3_needs_mts) else $error("v3 pcie without translation accepted");

	property p_v2_limits;
		@(posedge I_CLK) disable iff (I_SRST)
		(q.st == CFG_CHECK && q.arch == ARCH_V2 && (q.pcie || q.pe_cnt > V2_MAX_PE))
			|=> O_CFG_FAULT;
	endproperty
	a_v2_limits: assert property (p_v2_limits) else $error("v2 limit not enforced");

	property p_arch_allowed;
		@(posedge I_CLK) disable iff (I_SRST)
		O_CFG_VALID |-> q.arch != ARCH_RSVD;
	endproperty
	a_arch_allowed: assert property (p_arch_allowed) else $error("reserved arch running");

	property p_two_states;
		@(posedge I_CLK) disable iff (I_SRST)
		(O_CFG_VALID && q.arch == ARCH_V3) |-> O_SEC_TWO_STATES;
	endproperty
	a_two_states: assert property (p_two_states) else $error("v3 lacks two states");

	sequence s_msi_v3;
		I_MSI_VALID && running && q.pcie && q.arch == ARCH_V3 && q.mts;
	endsequence

	property p_msi_to_lpi;
		@(posedge I_CLK) disable iff (I_SRST)
		s_msi_v3 |=> O_MSI_LPI_VALID && !O_MSI_SPI_VALID
			&& O_MSI_LPI_ID == $past(I_MSI_DATA);
	endproperty
	a_msi_to_lpi: assert property (p_msi_to_lpi) else $error("message not sent to locality");

	property p_intx_level;
		@(posedge I_CLK) disable iff (I_SRST)
		(running && q.pcie) |=> O_INTX_LEVEL == $past(I_INTX);
	endproperty
	a_intx_level: assert property (p_intx_level) else $error("legacy level not followed");

	property p_sgi_reject;
		@(posedge I_CLK) disable iff (I_SRST)
		(I_SGI_VALID && I_SGI_ID >= SGI_LIMIT) |=> O_SGI_REJECT;
	endproperty
	a_sgi_reject: assert property (p_sgi_reject) else $error("out of range id not refused");

	property p_sgi_set;
		@(posedge I_CLK) disable iff (I_SRST)
		(I_SGI_VALID && I_SGI_ID == 4'h3 && I_SGI_TARGETS[1]) |=> O_SGI_PEND[11];
	endproperty
	a_sgi_set: assert property (p_sgi_set) else $error("software interrupt not pending");

endmodule : bsim_top

// *** bsim_pe_model.sv ***
module bsim_pe_model
	import bsim_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_set,
	input wire logic i_clr,
	input wire logic [3:0] i_src,
	input wire logic [2:0] i_pe,
	output logic [11:0][NUM_PE-1:0] o_lvl
);
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [11:0][NUM_PE-1:0] lvl;
	} bsim_pe_state_t;

	bsim_pe_state_t state;
	bsim_pe_state_t next_state;

	////////////////////////////////////////////////////////////////////////
	// a raised source holds until software clears it at the source
	always_comb begin
		next_state = state;
		if (i_set) begin
			next_state.lvl[i_src][i_pe] = 1'h1;
		end
		if (i_clr) begin
			next_state.lvl[i_src][i_pe] = 1'h0;
		end
	end

	// level register per source and element
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// each source goes straight to its own line, no glue between
	assign o_lvl = state.lvl;
endmodule : bsim_pe_model

// *** bsim_top_tb_top.sv ***
module bsim_top_tb_top
	import bsim_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic I_CLK, I_SRST, I_HAS_PCIE, I_HAS_MSG_TRANSLATION_SERVICE;
	logic [1:0] I_ARCH_SEL;
	logic [PE_CNT_W-1:0] I_PE_COUNT;
	logic I_PROF_PRESENT, I_SEL2_PRESENT, I_PE_V81;
	logic I_SGI_VALID, I_SGI_ACK_VALID, I_MSI_VALID;
	logic [3:0] I_SGI_ID;
	logic [NUM_PE-1:0] I_SGI_TARGETS;
	logic [2:0] I_SGI_ACK_PE, I_SGI_ACK_ID;
	logic [MSI_ID_W-1:0] I_MSI_DATA, O_MSI_SPI_ID, O_MSI_LPI_ID;
	logic [INTX_W-1:0] I_INTX, O_INTX_LEVEL;
	logic [NUM_PE*PPI_W-1:0] O_PPI_LEVEL;
	logic [NUM_PE*SGI_NUM-1:0] O_SGI_PEND, exp_pend;
	logic O_SGI_REJECT, O_MSI_SPI_VALID, O_MSI_LPI_VALID, O_MSI_DROP;
	logic O_CFG_VALID, O_CFG_FAULT, O_SEC_TWO_STATES;
	logic src_set, src_clr;
	logic [3:0] src_sel;
	logic [2:0] src_pe;
	logic [11:0][NUM_PE-1:0] lvl;
	int bad_count, comparisons;
	// line number of each source, in model source order
	localparam logic [4:0] SRC_ID [12] = '{5'h1e, 5'h1b, 5'h18, 5'h17,
		5'h16, 5'h15, 5'h1c, 5'h1a, 5'h19, 5'h1d, 5'h14, 5'h13};

	////////////////////////////////////////////////////////////////////////
	bsim_top u_bsim_top (.I_CLK(I_CLK), .I_SRST(I_SRST),
		.I_ARCH_SEL(I_ARCH_SEL), .I_HAS_PCIE(I_HAS_PCIE),
		.I_HAS_MSG_TRANSLATION_SERVICE(I_HAS_MSG_TRANSLATION_SERVICE),
		.I_PE_COUNT(I_PE_COUNT), .I_PROF_PRESENT(I_PROF_PRESENT),
		.I_SEL2_PRESENT(I_SEL2_PRESENT), .I_PE_V81(I_PE_V81),
		.I_NS_PHYS_TIMER_IRQ(lvl[0]), .I_VIRT_TIMER_IRQ(lvl[1]),
		.I_CROSS_TRIGGER_IRQ(lvl[2]), .I_PMU_OVERFLOW_IRQ(lvl[3]),
		.I_DEBUG_COMM_CHANNEL_IRQ(lvl[4]), .I_PROFILING_BUFFER_IRQ(lvl[5]),
		.I_NS_EL2_VIRT_TIMER_IRQ(lvl[6]), .I_NS_EL2_PHYS_TIMER_IRQ(lvl[7]),
		.I_MAINT_IRQ(lvl[8]), .I_SECURE_PHYS_TIMER_IRQ(lvl[9]),
		.I_SECURE_EL2_PHYS_TIMER_IRQ(lvl[10]),
		.I_SECURE_EL2_VIRT_TIMER_IRQ(lvl[11]),
		.I_SGI_VALID(I_SGI_VALID), .I_SGI_ID(I_SGI_ID),
		.I_SGI_TARGETS(I_SGI_TARGETS), .I_SGI_ACK_VALID(I_SGI_ACK_VALID),
		.I_SGI_ACK_PE(I_SGI_ACK_PE), .I_SGI_ACK_ID(I_SGI_ACK_ID),
		.I_MSI_VALID(I_MSI_VALID), .I_MSI_DATA(I_MSI_DATA), .I_INTX(I_INTX),
		.O_PPI_LEVEL(O_PPI_LEVEL), .O_SGI_PEND(O_SGI_PEND),
		.O_SGI_REJECT(O_SGI_REJECT), .O_MSI_SPI_VALID(O_MSI_SPI_VALID),
		.O_MSI_SPI_ID(O_MSI_SPI_ID), .O_MSI_LPI_VALID(O_MSI_LPI_VALID),
		.O_MSI_LPI_ID(O_MSI_LPI_ID), .O_MSI_DROP(O_MSI_DROP),
		.O_INTX_LEVEL(O_INTX_LEVEL), .O_CFG_VALID(O_CFG_VALID),
		.O_CFG_FAULT(O_CFG_FAULT), .O_SEC_TWO_STATES(O_SEC_TWO_STATES));

	bsim_pe_model u_bsim_pe_model (.i_clk(I_CLK), .i_srst(I_SRST),
		.i_set(src_set), .i_clr(src_clr), .i_src(src_sel), .i_pe(src_pe),
		.o_lvl(lvl));

	////////////////////////////////////////////////////////////////////////
	// clock, 4 ns period
	always #2 I_CLK = ~I_CLK;

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	// straps are set while reset is held; running after second edge
	task automatic do_reset(input logic [1:0] arch, input logic pcie,
		input logic mts, input logic [4:0] cnt, input logic gate);
		@(negedge I_CLK);
		I_SRST = 1'h1;
		I_ARCH_SEL = arch;
		I_HAS_PCIE = pcie;
		I_HAS_MSG_TRANSLATION_SERVICE = mts;
		I_PE_COUNT = cnt;
		I_PROF_PRESENT = gate;
		I_SEL2_PRESENT = gate;
		I_PE_V81 = gate;
		repeat (10) @(negedge I_CLK);
		I_SRST = 1'h0;
		repeat (3) @(negedge I_CLK);
	endtask : do_reset

	// one configuration: verdict, then a message and legacy levels
	task automatic run_cfg(input logic [1:0] arch, input logic pcie,
		input logic mts, input logic [4:0] cnt, input logic ok);
		logic locality_msg_interrupt;
		logic spi;
		do_reset(arch, pcie, mts, cnt, 1'h1);
		check(O_CFG_VALID, ok);
		check(O_CFG_FAULT, !ok);
		if (ok) begin
			check(O_SEC_TWO_STATES, arch == 2'h2);
		end
		locality_msg_interrupt = ok && pcie && arch == 2'h2 && mts;
		spi = ok && pcie && arch == 2'h1;
		I_MSI_VALID = 1'h1;
		I_MSI_DATA = 16'h1234;
		I_INTX = 4'ha;
		@(negedge I_CLK);
		I_MSI_VALID = 1'h0;
		check(O_MSI_LPI_VALID, locality_msg_interrupt);
		check(O_MSI_SPI_VALID, spi);
		check(O_MSI_DROP, !(locality_msg_interrupt || spi));
		if (locality_msg_interrupt) begin
			check(O_MSI_LPI_ID, 16'h1234);
		end
		if (spi) begin
			check(O_MSI_SPI_ID, 16'h1234);
		end
		check(O_INTX_LEVEL, (ok && pcie) ? 4'ha : 4'h0);
		I_INTX = 4'h5;
		@(negedge I_CLK);
		check({O_MSI_LPI_VALID, O_MSI_SPI_VALID, O_MSI_DROP}, 3'h0);
		check(O_INTX_LEVEL, (ok && pcie) ? 4'h5 : 4'h0);
	endtask : run_cfg

	// every source on every element lands on its own line only; the four gated sources land nowhere when gate is clear
	task automatic ppi_sweep(input logic gate);
		logic [127:0] exp;
		logic on;
		for (int s = 0; s < 12; s++) begin
			for (int p = 0; p < NUM_PE; p++) begin
				on = gate || !(SRC_ID[s] inside {5'h15, 5'h1c, 5'h14, 5'h13});
				exp = on ? (128'h1 << (16 * p + int'(SRC_ID[s]) - 16)) : '0;
				src_sel = 4'(s);
				src_pe = 3'(p);
				src_set = 1'h1;
				@(negedge I_CLK);
				src_set = 1'h0;
				@(negedge I_CLK);
				check(O_PPI_LEVEL[63:0], exp[63:0]);
				check(O_PPI_LEVEL[127:64], exp[127:64]);
				repeat (2) @(negedge I_CLK);
				check(O_PPI_LEVEL, exp);
				src_clr = 1'h1;
				@(negedge I_CLK);
				src_clr = 1'h0;
				@(negedge I_CLK);
				check(O_PPI_LEVEL, 128'h0);
			end
		end
	endtask : ppi_sweep

	// one software interrupt cycle; caller releases with sgi_idle
	task automatic sgi_op(input logic vs, input logic [3:0] id,
		input logic [7:0] tgt, input logic va, input logic [2:0] ape,
		input logic [2:0] aid);
		I_SGI_VALID = vs;
		I_SGI_ID = id;
		I_SGI_TARGETS = tgt;
		I_SGI_ACK_VALID = va;
		I_SGI_ACK_PE = ape;
		I_SGI_ACK_ID = aid;
		if (va) begin
			exp_pend[8 * ape + aid] = 1'h0;
		end
		for (int t = 0; t < NUM_PE; t++) begin
			if (vs && id < 4'h8 && tgt[t]) begin
				exp_pend[8 * t + id[2:0]] = 1'h1;
			end
		end
		@(negedge I_CLK);
		check(O_SGI_PEND, exp_pend);
		check(O_SGI_REJECT, vs && id >= 4'h8);
	endtask : sgi_op

	task automatic sgi_idle();
		I_SGI_VALID = 1'h0;
		I_SGI_ACK_VALID = 1'h0;
		@(negedge I_CLK);
		check(O_SGI_REJECT, 1'h0);
	endtask : sgi_idle

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{I_CLK, I_SRST, I_HAS_PCIE, I_HAS_MSG_TRANSLATION_SERVICE} = '0;
		{I_ARCH_SEL, I_PE_COUNT, I_PROF_PRESENT, I_SEL2_PRESENT} = '0;
		{I_PE_V81, I_SGI_VALID, I_SGI_ACK_VALID, I_MSI_VALID} = '0;
		{I_SGI_ID, I_SGI_TARGETS, I_SGI_ACK_PE, I_SGI_ACK_ID} = '0;
		{I_MSI_DATA, I_INTX, src_set, src_clr, src_sel, src_pe} = '0;
		exp_pend = '0;
		run_cfg(2'h0, 1'h0, 1'h0, 5'h08, 1'h1);
		run_cfg(2'h0, 1'h1, 1'h0, 5'h08, 1'h0);
		run_cfg(2'h0, 1'h0, 1'h0, 5'h09, 1'h0);
		run_cfg(2'h1, 1'h1, 1'h0, 5'h08, 1'h1);
		run_cfg(2'h1, 1'h0, 1'h0, 5'h09, 1'h0);
		run_cfg(2'h2, 1'h1, 1'h0, 5'h08, 1'h0);
		run_cfg(2'h2, 1'h0, 1'h0, 5'h08, 1'h1);
		run_cfg(2'h3, 1'h0, 1'h0, 5'h08, 1'h0);
		run_cfg(2'h2, 1'h1, 1'h1, 5'h10, 1'h1);
		ppi_sweep(1'h1);
		do_reset(2'h2, 1'h0, 1'h0, 5'h08, 1'h0);
		ppi_sweep(1'h0);
		for (int i = 0; i < 8; i++) begin
			sgi_op(1'h1, 4'(i), 8'h81, 1'h0, 3'h0, 3'h0);
		end
		sgi_op(1'h1, 4'h8, 8'hff, 1'h0, 3'h0, 3'h0);
		sgi_op(1'h1, 4'hf, 8'hff, 1'h0, 3'h0, 3'h0);
		sgi_op(1'h0, 4'h0, 8'h00, 1'h1, 3'h7, 3'h5);
		sgi_op(1'h1, 4'h3, 8'h02, 1'h1, 3'h1, 3'h3);
		sgi_op(1'h0, 4'h0, 8'h00, 1'h1, 3'h1, 3'h3);
		sgi_idle();
		summarize();
	end

	// watchdog well beyond the expected run of some 1300 cycles
	initial begin
		#40000;
		bad_count++;
		summarize();
	end
endmodule : bsim_top_tb_top
